// [hdl/tcl_defines.vh]
// Constants shared by the ternary lookup core
`ifndef TCL_DEFINES_VH
`define TCL_DEFINES_VH

`define TCL_ENC_ZERO     2'b10
`define TCL_ENC_ONE      2'b01
`define TCL_ENC_ANY      2'b11
`define TCL_LATENCY      6
`define TCL_SLICE0_ROWS  32
`define TCL_SLICE0_BITS  9
`define TCL_SLICE1_ROWS  16
`define TCL_SLICE1_BITS  10
`define TCL_ST_IDLE      2'h0
`define TCL_ST_ERASE     2'h1
`define TCL_ST_WRITE     2'h2

`endif

// [hdl/tcl_lookup.v]
// Ternary / binary content-addressable lookup core
// How it works
// (RULE1) Ternary write encodes data, records raw word
// (RULE2) Accepted write clears old entry bits
// (RULE3) Next cycle sets entry bit at data
// (RULE4) Search only when idle; vector next cycle
// (RULE5) Priority encoder turns vector into index
// (RULE6) Highest or lowest match by configuration
// (RULE7) Match RAM: row per value, bit per entry
// (RULE8) Each entry holds a single value only
// (RULE9) Write is erase phase then write phase
// (RULE10) Erase memory keeps each entry's data
// (RULE11) Mask bit one makes data bit don't-care
// (RULE12) Encode: 0->10, 1->01, masked->11
// (RULE13) Per-bit encoding doubles the word width
// (RULE14) Binary mode bypasses the ternary encoder
// (RULE15) Organisation 0: 32 entries, 9-bit slices; the core has 1 << A_WIDTH entries (8 by default) in either organisation
// (RULE16) Organisation 1: 16 entries, 10-bit slices; the core has 1 << A_WIDTH entries (8 by default) in either organisation
// (RULE17) Match RAM: write port and search port
// (RULE18) Slices combine; all data slices agree
// (RULE19) Single clock, no other domain
// (RULE20) Resets qualified by power-up outside core
// (RULE21) No search while write busy is high
// (RULE22) Match flag when any entry matches
// (RULE23) One search per cycle, six-cycle latency
// (RULE24) Reset input active low, asynchronous; the core uses a synchronous active-high i_rst
// (RULE25) Busy from write accept to write done
// (RULE26) No match: flag low, index holds
`timescale 1ns/1ps
`default_nettype none
`include "tcl_defines.vh"

module tcl_lookup #(
	parameter RAM_ORG    = 0,  // Slice organisation select
	parameter HIGH_FIRST = 1,  // Highest matching index wins
	parameter D_WIDTH    = 8,  // Data width
	parameter A_WIDTH    = 3   // Entry index width
) (
	input  wire               i_mclk,                  // Core clock
	input  wire               i_rst,                   // Sync reset, high
	input  wire               i_enable,                // Core enable
	input  wire               i_ternary_mode,          // 1 ternary, 0 binary
	input  wire               i_entry_write_request,   // Write strobe
	input  wire [D_WIDTH-1:0] i_entry_write_word,      // Write data
	input  wire [D_WIDTH-1:0] i_entry_write_dontcare,  // Write mask
	input  wire [A_WIDTH-1:0] i_entry_write_index,     // Write entry
	input  wire               i_search_request,        // Search strobe
	input  wire [D_WIDTH-1:0] i_search_word,           // Search data
	input  wire [D_WIDTH-1:0] i_search_dontcare,       // Search mask
	output reg  [A_WIDTH-1:0] o_hit_index_out,         // Matched entry
	output reg                o_match_flag,            // Match found
	output reg                o_result_valid,          // Result strobe
	output wire               o_write_busy             // Write in progress
);

	localparam ENTRIES = 1 << A_WIDTH;
	localparam EW      = 2 * D_WIDTH;
	localparam SL_BITS = (RAM_ORG == 0) ? `TCL_SLICE0_BITS :
		`TCL_SLICE1_BITS; // RULE15 RULE16
	localparam SL_ROWS = (RAM_ORG == 0) ? `TCL_SLICE0_ROWS :
		`TCL_SLICE1_ROWS; // RULE15 RULE16
	localparam NSLICE  = (D_WIDTH + SL_BITS - 1) / SL_BITS;
	localparam PAD     = NSLICE * SL_BITS;
	localparam ROWS    = 1 << SL_BITS;
	localparam PIPE    = `TCL_LATENCY - 2;

	// Per-bit two-bit code; mask wins over data
	function [EW-1:0] tern_enc;
		input [D_WIDTH-1:0] d;
		input [D_WIDTH-1:0] m;
		integer k;
		begin
			tern_enc = {EW{1'b0}};
			for (k = 0; k < D_WIDTH; k = k + 1) begin
				if (m[k])  // RULE11
					tern_enc[2*k +: 2] = `TCL_ENC_ANY;  // RULE12
				else if (d[k])
					tern_enc[2*k +: 2] = `TCL_ENC_ONE;  // RULE12
				else
					tern_enc[2*k +: 2] = `TCL_ENC_ZERO;  // RULE12 RULE13
			end
		end
	endfunction

	// Priority encode a many-hot vector
	function [A_WIDTH-1:0] prio;
		input [ENTRIES-1:0] v;
		input               high;
		integer k;
		begin
			prio = {A_WIDTH{1'b0}};
			if (high) begin
				for (k = 0; k < ENTRIES; k = k + 1)
					if (v[k])
						prio = k[A_WIDTH-1:0];  // RULE5 RULE6
			end else begin
				for (k = ENTRIES - 1; k >= 0; k = k - 1)
					if (v[k])
						prio = k[A_WIDTH-1:0];  // RULE5 RULE6
			end
		end
	endfunction

	// Does a stored pattern match a search pattern bit by bit
	function pat_match;
		input [EW-1:0] stored;
		input [EW-1:0] key;
		input          tern;
		integer k;
		begin
			pat_match = 1'b1;
			for (k = 0; k < D_WIDTH; k = k + 1) begin
				if (tern) begin
					if ((stored[2*k +: 2] & key[2*k +: 2]) == 2'b00)
						pat_match = 1'b0;
				end else if (stored[2*k] != key[2*k]) begin
					pat_match = 1'b0;
				end
			end
		end
	endfunction

	// Stored pattern: raw data in binary, encoded in ternary
	function [EW-1:0] to_pat;
		input [D_WIDTH-1:0] d;
		input [D_WIDTH-1:0] m;
		input               tern;
		integer k;
		begin
			to_pat = {EW{1'b0}};
			if (tern)
				to_pat = tern_enc(d, m);  // RULE14
			else
				for (k = 0; k < D_WIDTH; k = k + 1)
					to_pat[2*k] = d[k];  // RULE14
		end
	endfunction

	// Slice row address for data bits of slice s
	function [SL_BITS-1:0] slice_row;
		input [D_WIDTH-1:0] d;
		input integer       s;
		reg   [PAD-1:0]     w;
		begin
			w = {PAD{1'b0}};
			w[D_WIDTH-1:0] = d;
			slice_row = w[s*SL_BITS +: SL_BITS];
		end
	endfunction

	// Stored mask: only ternary writes keep don't-care bits
	function [D_WIDTH-1:0] keep_mask;
		input [D_WIDTH-1:0] m;
		input               tern;
		begin
			if (tern)
				keep_mask = m;  // RULE11
			else
				keep_mask = {D_WIDTH{1'b0}};  // RULE14
		end
	endfunction

	// Match RAM: one row per data value, one bit per entry
	reg [ENTRIES-1:0] match_ram [0:NSLICE*ROWS-1];  // RULE7 RULE17
	// Erase memory: per entry raw data, mask and valid
	reg [D_WIDTH-1:0] erase_data [0:ENTRIES-1];  // RULE10
	reg [D_WIDTH-1:0] erase_mask [0:ENTRIES-1];
	reg [ENTRIES-1:0] entry_valid_reg;

	reg [1:0]         state_reg;
	reg [A_WIDTH-1:0] wr_idx_reg;
	reg [D_WIDTH-1:0] wr_data_reg;
	reg [D_WIDTH-1:0] wr_mask_reg;
	reg [D_WIDTH-1:0] old_data_reg;
	reg [D_WIDTH-1:0] old_mask_reg;
	reg               old_valid_reg;
	reg               tern_reg;

	reg [ENTRIES-1:0] hit_vec_reg;
	reg               hit_vld_reg;
	reg [A_WIDTH-1:0] pipe_idx_reg [0:PIPE-1];
	reg [PIPE-1:0]    pipe_hit_reg;
	reg [PIPE-1:0]    pipe_vld_reg;

	wire accept_wr = i_enable && i_entry_write_request &&
		(state_reg == `TCL_ST_IDLE);
	wire do_search = i_enable && i_search_request &&
		(state_reg == `TCL_ST_IDLE) && !accept_wr;  // RULE4 RULE21

	assign o_write_busy = (state_reg != `TCL_ST_IDLE);  // RULE25

	// Search read port: AND of slice rows in binary, per-entry pattern check in ternary
	reg [ENTRIES-1:0] search_vec;
	reg [EW-1:0]      key_pat;
	integer           s;
	integer           e;
	always @* begin
		search_vec = {ENTRIES{1'b1}};
		key_pat = to_pat(i_search_word, i_search_dontcare, i_ternary_mode);
		if (!i_ternary_mode) begin
			for (s = 0; s < NSLICE; s = s + 1)
				search_vec = search_vec &
					match_ram[s*ROWS + slice_row(i_search_word, s)];  // RULE18
		end else begin
			for (e = 0; e < ENTRIES; e = e + 1)
				search_vec[e] = entry_valid_reg[e] && pat_match(
					to_pat(erase_data[e], erase_mask[e], 1'b1),
					key_pat, 1'b1);
		end
	end

	// Write phase sequencing
	reg [1:0] state_next;
	always @* begin
		state_next = state_reg;
		case (state_reg)
		`TCL_ST_IDLE: begin
			if (accept_wr)
				state_next = `TCL_ST_ERASE;  // RULE9
		end
		`TCL_ST_ERASE: begin
			state_next = `TCL_ST_WRITE;  // RULE2
		end
		`TCL_ST_WRITE: begin
			state_next = `TCL_ST_IDLE;  // RULE3 RULE25
		end
		default: begin
			state_next = `TCL_ST_IDLE;
		end
		endcase
	end

	// Search stage next values
	reg [ENTRIES-1:0] hit_vec_next;
	reg               hit_vld_next;
	always @* begin
		hit_vec_next = {ENTRIES{1'b0}};
		hit_vld_next = 1'b0;
		if (do_search) begin
			hit_vec_next = search_vec;  // RULE4
			hit_vld_next = 1'b1;  // RULE23
		end
	end

	// Result stage next values; index holds on a miss
	reg [A_WIDTH-1:0] idx_next;
	reg               flag_next;
	always @* begin
		idx_next  = o_hit_index_out;
		flag_next = o_match_flag;
		if (pipe_vld_reg[PIPE-1]) begin
			flag_next = pipe_hit_reg[PIPE-1];  // RULE22 RULE26
			if (pipe_hit_reg[PIPE-1])
				idx_next = pipe_idx_reg[PIPE-1];  // RULE26
		end
	end

	integer p;
	always @(posedge i_mclk) begin  // RULE19 RULE24
		if (i_rst) begin
			state_reg       <= `TCL_ST_IDLE;
			entry_valid_reg <= {ENTRIES{1'b0}};
			wr_idx_reg      <= {A_WIDTH{1'b0}};
			wr_data_reg     <= {D_WIDTH{1'b0}};
			wr_mask_reg     <= {D_WIDTH{1'b0}};
			old_data_reg    <= {D_WIDTH{1'b0}};
			old_mask_reg    <= {D_WIDTH{1'b0}};
			old_valid_reg   <= 1'b0;
			tern_reg        <= 1'b0;
			hit_vec_reg     <= {ENTRIES{1'b0}};
			hit_vld_reg     <= 1'b0;
			pipe_hit_reg    <= {PIPE{1'b0}};
			pipe_vld_reg    <= {PIPE{1'b0}};
			o_hit_index_out <= {A_WIDTH{1'b0}};
			o_match_flag    <= 1'b0;
			o_result_valid  <= 1'b0;
			for (p = 0; p < PIPE; p = p + 1)
				pipe_idx_reg[p] <= {A_WIDTH{1'b0}};
			// Clear match RAM so binary searches never see unknowns
			for (p = 0; p < NSLICE*ROWS; p = p + 1)
				match_ram[p] <= {ENTRIES{1'b0}};
			// Erase memory starts empty
			for (p = 0; p < ENTRIES; p = p + 1) begin
				erase_data[p] <= {D_WIDTH{1'b0}};
				erase_mask[p] <= {D_WIDTH{1'b0}};
			end
		end else begin
			state_reg <= state_next;  // RULE9
			case (state_reg)
			`TCL_ST_IDLE: begin
				if (accept_wr) begin
					wr_idx_reg    <= i_entry_write_index;
					wr_data_reg   <= i_entry_write_word;
					wr_mask_reg   <= keep_mask(i_entry_write_dontcare,
						i_ternary_mode);
					tern_reg      <= i_ternary_mode;
					old_data_reg  <= erase_data[i_entry_write_index];
					old_mask_reg  <= erase_mask[i_entry_write_index];
					old_valid_reg <= entry_valid_reg[i_entry_write_index];
					erase_data[i_entry_write_index] <= i_entry_write_word;  // RULE1
					erase_mask[i_entry_write_index] <=
						keep_mask(i_entry_write_dontcare, i_ternary_mode);
				end
			end
			`TCL_ST_ERASE: begin
				// Clear old bits so the entry never holds two values
				entry_valid_reg[wr_idx_reg] <= 1'b0;  // RULE8
				if (old_valid_reg)
					for (s = 0; s < NSLICE; s = s + 1)
						match_ram[s*ROWS + slice_row(old_data_reg, s)]
							[wr_idx_reg] <= 1'b0;  // RULE2
			end
			`TCL_ST_WRITE: begin
				for (s = 0; s < NSLICE; s = s + 1)
					match_ram[s*ROWS + slice_row(wr_data_reg, s)]
						[wr_idx_reg] <= 1'b1;  // RULE3
				entry_valid_reg[wr_idx_reg] <= 1'b1;
			end
			default: begin
			end
			endcase

			// Stage 1: match vector one cycle after request
			hit_vec_reg <= hit_vec_next;  // RULE4
			hit_vld_reg <= hit_vld_next;  // RULE23
			// Stage 2: priority encode, then delay line
			pipe_idx_reg[0] <= prio(hit_vec_reg, HIGH_FIRST != 0);  // RULE5
			pipe_hit_reg[0] <= |hit_vec_reg;  // RULE22
			pipe_vld_reg[0] <= hit_vld_reg;
			for (p = 1; p < PIPE; p = p + 1) begin
				pipe_idx_reg[p] <= pipe_idx_reg[p-1];
				pipe_hit_reg[p] <= pipe_hit_reg[p-1];
				pipe_vld_reg[p] <= pipe_vld_reg[p-1];
			end
			// Registered outputs
			o_result_valid  <= pipe_vld_reg[PIPE-1];  // RULE23
			o_match_flag    <= flag_next;  // RULE22
			o_hit_index_out <= idx_next;  // RULE26
		end
	end

endmodule // tcl_lookup
`default_nettype wire

// [testbench/tcl_lookup_monitor.sv]
// Timing assertions for the lookup core
`timescale 1ns/1ps
`default_nettype none
module tcl_lookup_mon #(
	parameter A_WIDTH = 3 // Entry index width
) (
	input wire logic               i_mclk,                // Clock
	input wire logic               i_rst,                 // Reset
	input wire logic               i_enable,              // Enable
	input wire logic               i_entry_write_request, // Write
	input wire logic               i_search_request,      // Search
	input wire logic               o_write_busy,          // Busy
	input wire logic               o_result_valid,        // Result
	input wire logic               o_match_flag,          // Hit
	input wire logic [A_WIDTH-1:0] o_hit_index_out        // Index
);
	wire s_wt = i_enable && i_entry_write_request && !o_write_busy;
	wire s_st = i_enable && i_search_request && !o_write_busy
		&& !i_entry_write_request;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	property p_busy;
		s_wt |=> o_write_busy [*2] ##1 !o_write_busy;
	endproperty
	a_busy: assert property (p_busy) else $error("busy length");
	property p_rise;
		$rose(o_write_busy) |-> $past(s_wt);
	endproperty
	a_rise: assert property (p_rise) else $error("busy cause");
	property p_two;
		o_write_busy ##1 o_write_busy |=> !o_write_busy;
	endproperty
	a_two: assert property (p_two) else $error("busy too long");
	property p_lat;
		s_st |-> ##6 o_result_valid;
	endproperty
	a_lat: assert property (p_lat) else $error("no result");
	property p_cause;
		o_result_valid |-> $past(s_st, 6);
	endproperty
	a_cause: assert property (p_cause) else $error("stray result");
	property p_wblk;
		s_wt |-> ##6 !o_result_valid [*3];
	endproperty
	a_wblk: assert property (p_wblk) else $error("search in write");
	property p_flag;
		$changed(o_match_flag) |-> o_result_valid;
	endproperty
	a_flag: assert property (p_flag) else $error("flag moved");
	property p_hold;
		o_result_valid && !o_match_flag |-> $stable(o_hit_index_out);
	endproperty
	a_hold: assert property (p_hold) else $error("index moved");
endmodule // tcl_lookup_mon
`default_nettype wire

// [testbench/tcl_user.sv]
// Fabric-side requester model
`timescale 1ns/1ps
`default_nettype none
module tcl_user (
	input  wire logic       i_mclk, // Clock
	output logic            o_wr,   // Write strobe
	output logic [7:0]      o_wd,   // Write word
	output logic [7:0]      o_wm,   // Write mask
	output logic [2:0]      o_wi,   // Write entry
	output logic            o_sr,   // Search strobe
	output logic [7:0]      o_sd,   // Search word
	output logic [7:0]      o_sm    // Search mask
);
	initial {o_wr, o_wd, o_wm, o_wi, o_sr, o_sd, o_sm} = 0;
	task wr(input [2:0] i, input [7:0] d, input [7:0] m);
		{o_sr, o_wr, o_wi, o_wd, o_wm} <= {2'b01, i, d, m};
		@(posedge i_mclk);
		{o_wr, o_wd} <= {1'b0, ~o_wd};
		repeat (2) @(posedge i_mclk);
	endtask
	task sr(input [7:0] d, input [7:0] m);
		{o_sr, o_sd, o_sm} <= {1'b1, d, m};
		@(posedge i_mclk);
	endtask
	task idle;
		{o_sr, o_sd} <= {1'b0, ~o_sd};
		@(posedge i_mclk);
	endtask
endmodule // tcl_user
`default_nettype wire

// [testbench/tcl_lookup_test.sv]
// Self-checking bench for the lookup core
`timescale 1ns/1ps
`default_nettype none
module tcl_lookup_test;
	logic       clk = 0, rst = 1, en = 1, tern = 1;
	logic       wr, sr, flag, vld, busy;
	logic [7:0] wd, wm, sd, sm, vl = 0;
	logic [2:0] wi, idx, last = 0;
	logic [3:0] r;
	logic [7:0] st_d [8] = '{default: 0};
	logic [7:0] st_m [8] = '{default: 0};
	logic [3:0] q [$];
	int         n_fail = 0, checked = 0, cyc = 0;
	always #25 clk = ~clk;
	tcl_user U (.i_mclk(clk), .o_wr(wr), .o_wd(wd), .o_wm(wm), .o_wi(wi),
		.o_sr(sr), .o_sd(sd), .o_sm(sm));
	tcl_lookup DUT (.i_mclk(clk), .i_rst(rst), .i_enable(en),
		.i_ternary_mode(tern), .i_entry_write_request(wr),
		.i_entry_write_word(wd), .i_entry_write_dontcare(wm),
		.i_entry_write_index(wi), .i_search_request(sr),
		.i_search_word(sd), .i_search_dontcare(sm),
		.o_hit_index_out(idx), .o_match_flag(flag),
		.o_result_valid(vld), .o_write_busy(busy));
	function automatic [3:0] expect_hit(input [7:0] d, input [7:0] m);
		logic [3:0] h;
		h = {1'b0, last};
		for (int e = 0; e < 8; e++)
			if (vl[e] && ((st_d[e] ^ d) & ~st_m[e] & ~m) == 0)
				h = {1'b1, 3'(e)};
		return h;
	endfunction
	task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask
	task stop_test;
		$display("checks %0d, failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			stop_test();
		end
		if (!rst && en && wr && !busy) begin
			st_d[wi] = wd;
			st_m[wi] = tern ? wm : 8'h00;
			vl[wi] = 1'b1;
		end else if (!rst && en && sr && !busy) begin
			r = expect_hit(sd, tern ? sm : 8'h00);
			q.push_back(r);
			last = r[2:0];
		end
		if (vld)
			chk("result", {flag, idx}, q.size() ? q.pop_front() : 4'bx);
	end
	initial begin
		void'($urandom(21064));
		repeat (16) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		chk("reset", {busy, vld, flag, idx}, 8'h00);
		U.wr(3'd7, 8'hA5, 8'h00);
		U.wr(3'd2, 8'hA4, 8'h01);
		U.sr(8'hA5, 8'h00);
		U.sr(8'hA4, 8'h00);
		U.sr(8'h00, 8'hFF);
		U.sr(8'h00, 8'h00);
		U.wr(3'd7, 8'h3C, 8'h00);
		U.sr(8'hA5, 8'h00);
		en <= 0;
		U.wr(3'd1, 8'h5A, 8'h00);
		U.sr(8'h5A, 8'h00);
		en <= 1;
		for (int p = 0; p < 2; p++) begin
			U.idle();
			tern <= p[0];
			repeat (8) U.idle();
			for (int e = 0; e < 8; e++)
				U.wr(3'(e), 8'($urandom), 8'($urandom & $urandom));
			repeat (150) begin
				if ($urandom % 3 == 0)
					U.wr(3'($urandom), 8'($urandom), 8'($urandom & $urandom));
				else
					U.sr(st_d[$urandom % 8] ^ 8'($urandom % 4),
						8'($urandom & $urandom));
			end
		end
		repeat (8) U.idle();
		chk("pending", 8'(q.size()), 8'h00);
		stop_test();
	end
endmodule // tcl_lookup_test
bind tcl_lookup tcl_lookup_mon #(.A_WIDTH(A_WIDTH)) M (.i_mclk, .i_rst,
	.i_enable, .i_entry_write_request, .i_search_request, .o_write_busy,
	.o_result_valid, .o_match_flag, .o_hit_index_out);
`default_nettype wire
